// >>> inc/chop_seq_pkg.sv
// constants, register map and timing tables for the chop sequencer
package chop_seq_pkg;
    localparam logic [7:0] ADDR_CONTROL   = 8'h00;
    localparam logic [7:0] ADDR_RATE_CFG  = 8'h04;
    localparam logic [7:0] ADDR_STATUS    = 8'h08;
    localparam logic [7:0] ADDR_RESULT    = 8'h0c;
    localparam logic [7:0] ADDR_DELAY     = 8'h10;

    // data_rate_config fields
    localparam int RATE_LSB    = 0;
    localparam int RATE_W      = 4;
    localparam int FILTER_BIT  = 4;   // 1: third-order sinc, 0: low latency
    localparam int CHOP_BIT    = 5;
    localparam int CONT_BIT    = 6;   // 1: continuous, 0: single shot
    localparam logic [7:0] RATE_CFG_RESET = 8'h00;
    localparam logic [7:0] RATE_CFG_MASK  = 8'h7f;

    // control fields
    localparam int START_BIT = 0;
    localparam int STOP_BIT  = 1;

    // status fields
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_POL_BIT   = 1;
    localparam int ST_READY_BIT = 2;
    localparam int ST_CHOP_BIT  = 3;

    localparam int            DATA_W          = 24;
    localparam int            CNT_W           = 24;
    localparam int            DELAY_W         = 16;
    localparam logic [15:0]   DELAY_RESET     = 16'h000e;  // 14 modulator periods
    localparam int            NUM_RATES       = 14;

    // one polarity conversion, modulator periods, low-latency filter
    function automatic logic [CNT_W-1:0] ll_periods(input logic [RATE_W-1:0] idx);
        unique case (idx)
            4'h0: ll_periods = 24'd104065;
            4'h1: ll_periods = 24'd52865;
            4'h2: ll_periods = 24'd27265;
            4'h3: ll_periods = 24'd15425;
            4'h4: ll_periods = 24'd14465;
            4'h5: ll_periods = 24'd5160;
            4'h6: ll_periods = 24'd4329;
            4'h7: ll_periods = 24'd2600;
            4'h8: ll_periods = 24'd1320;
            4'h9: ll_periods = 24'd680;
            4'ha: ll_periods = 24'd360;
            4'hb: ll_periods = 24'd296;
            4'hc: ll_periods = 24'd168;
            default: ll_periods = 24'd104;
        endcase
    endfunction

    // one polarity conversion, modulator periods, sinc3 filter (three to settle)
    function automatic logic [CNT_W-1:0] sinc3_periods(input logic [RATE_W-1:0] idx);
        unique case (idx)
            4'h0: sinc3_periods = 24'd307265;
            4'h1: sinc3_periods = 24'd153665;
            4'h2: sinc3_periods = 24'd76865;
            4'h3: sinc3_periods = 24'd46145;
            4'h4: sinc3_periods = 24'd38465;
            4'h5: sinc3_periods = 24'd15425;
            4'h6: sinc3_periods = 24'd12857;
            4'h7: sinc3_periods = 24'd7745;
            4'h8: sinc3_periods = 24'd3905;
            4'h9: sinc3_periods = 24'd1985;
            4'ha: sinc3_periods = 24'd1025;
            4'hb: sinc3_periods = 24'd808;
            4'hc: sinc3_periods = 24'd424;
            default: sinc3_periods = 24'd232;
        endcase
    endfunction

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_SETTLE,
        SEQ_CONVERT
    } seq_state_e;
endpackage

// >>> logic/global_chop_sequencer.sv
// global chop conversion sequencer with apb register access
//
// Contract
// - chop pairs run only when the chop enable bit is set; else single polarity.
// - first conversion after each start or restart uses normal input polarity.
// - second conversion swaps polarity; result is half the difference of both.
// - low-latency filter with chop gives first output after about two conversions.
// - sinc3 filter with chop gives first output after about six conversions.
// - continuous chop conversions after the first take half the first's time.
// - continuous chop averages the latest two conversions on every data cycle.
// - low latency 2.5 SPS first 208130, later 104065; 100 SPS first 5200.
// - a sequence starts on start pin rising edge or a start command.
// - settling delay is applied once per conversion, so twice before the first chop result, once per later continuous result.
`timescale 1ns/1ps
module global_chop_sequencer #(
    parameter int MOD_DIV     = 24,   // pclk cycles per modulator period
    parameter int COUNT_SHIFT = 0     // shortens conversion counts for simulation
) (
    input  wire logic        pclk,          // 100 MHz clock
    input  wire logic        presetn,       // async reset, active low
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb enable
    input  wire logic        pwrite,        // apb direction
    input  wire logic [7:0]  paddr,         // apb byte address
    input  wire logic [31:0] pwdata,        // apb write data
    output logic      [31:0] prdata,        // apb read data
    output logic             pready,        // apb ready
    output logic             pslverr,       // apb error on unmapped address
    input  wire logic        start_pin,     // asynchronous start pin
    input  wire logic [23:0] filter_data,   // filtered conversion value, same clock
    output logic             polarity_swap, // high while inputs are reversed
    output logic             conv_active,   // sequencer busy
    output logic      [23:0] result,        // corrected result
    output logic             result_valid   // one-cycle pulse per new result
);
    localparam int DW = chop_seq_pkg::DATA_W;
    localparam int CW = chop_seq_pkg::CNT_W;

    logic [7:0]                         rate_cfg;
    logic [chop_seq_pkg::DELAY_W-1:0]   delay_cfg;
    logic                               ready_flag;
    logic                               start_cmd;
    logic                               stop_cmd;
    logic [2:0]                         pin_sync;
    logic                               chop_prev;
    logic [$clog2(MOD_DIV+1)-1:0]       div_cnt;
    logic                               mod_tick;
    logic [CW-1:0]                      cnt;
    logic [DW-1:0]                      prev_sample;
    logic                               have_prev;
    chop_seq_pkg::seq_state_e           state;

    wire apb_acc   = psel & penable & pready;
    wire apb_wr    = apb_acc & pwrite;
    wire apb_rd    = apb_acc & ~pwrite;
    wire chop_en   = rate_cfg[chop_seq_pkg::CHOP_BIT];
    wire cont_mode = rate_cfg[chop_seq_pkg::CONT_BIT];
    wire [chop_seq_pkg::RATE_W-1:0] rate_idx =
        rate_cfg[chop_seq_pkg::RATE_LSB +: chop_seq_pkg::RATE_W];
    wire pin_rise  = pin_sync[1] & ~pin_sync[2];
    wire go        = pin_rise | start_cmd;
    wire chop_chg  = chop_en != chop_prev;
    wire restart   = go | (chop_chg & (state != chop_seq_pkg::SEQ_IDLE));

    function automatic logic unmapped(input logic [7:0] a);
        unmapped = !(a == chop_seq_pkg::ADDR_CONTROL || a == chop_seq_pkg::ADDR_RATE_CFG ||
                     a == chop_seq_pkg::ADDR_STATUS  || a == chop_seq_pkg::ADDR_RESULT   ||
                     a == chop_seq_pkg::ADDR_DELAY);
    endfunction

    // per-conversion length; sinc3 counts already hold three settling conversions
    function automatic logic [CW-1:0] conv_len(input logic sinc3,
                                               input logic [chop_seq_pkg::RATE_W-1:0] idx);
        logic [CW-1:0] raw;
        raw = sinc3 ? chop_seq_pkg::sinc3_periods(idx)
                    : chop_seq_pkg::ll_periods(idx);
        raw = raw >> COUNT_SHIFT;
        conv_len = (raw == '0) ? CW'(1) : raw;
    endfunction

    function automatic logic [DW-1:0] average(input logic [DW-1:0] a, input logic [DW-1:0] b);
        logic signed [DW:0] s;
        s = $signed({a[DW-1], a}) + $signed({b[DW-1], b});
        average = s[DW:1];
    endfunction

    // apb handshake: one wait cycle, registered read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= unmapped(paddr);
            prdata  <= 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    chop_seq_pkg::ADDR_RATE_CFG: prdata <= {24'h00_0000, rate_cfg};
                    chop_seq_pkg::ADDR_STATUS:   prdata <= {28'h000_0000, chop_en, ready_flag,
                                                            polarity_swap, conv_active};
                    chop_seq_pkg::ADDR_RESULT:   prdata <= {8'h00, result};
                    chop_seq_pkg::ADDR_DELAY:    prdata <= {16'h0000, delay_cfg};
                    default:                     prdata <= 32'h0000_0000;
                endcase
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_cfg  <= chop_seq_pkg::RATE_CFG_RESET;
            delay_cfg <= chop_seq_pkg::DELAY_RESET;
        end else if (apb_wr && !unmapped(paddr)) begin
            if (paddr == chop_seq_pkg::ADDR_RATE_CFG)
                rate_cfg <= pwdata[7:0] & chop_seq_pkg::RATE_CFG_MASK;
            if (paddr == chop_seq_pkg::ADDR_DELAY)
                delay_cfg <= pwdata[chop_seq_pkg::DELAY_W-1:0];
        end
    end

    // command strobes from control writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_cmd <= 1'b0;
            stop_cmd  <= 1'b0;
        end else begin
            start_cmd <= apb_wr && paddr == chop_seq_pkg::ADDR_CONTROL &&
                         pwdata[chop_seq_pkg::START_BIT];
            stop_cmd  <= apb_wr && paddr == chop_seq_pkg::ADDR_CONTROL &&
                         pwdata[chop_seq_pkg::STOP_BIT];
        end
    end

    // start pin synchroniser and chop enable history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync  <= 3'b000;
            chop_prev <= 1'b0;
        end else begin
            pin_sync  <= {pin_sync[1:0], start_pin};
            chop_prev <= chop_en;
        end
    end

    // modulator period enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt  <= '0;
            mod_tick <= 1'b0;
        end else if (div_cnt == ($clog2(MOD_DIV+1))'(MOD_DIV - 1)) begin
            div_cnt  <= '0;
            mod_tick <= 1'b1;
        end else begin
            div_cnt  <= div_cnt + 1'b1;
            mod_tick <= 1'b0;
        end
    end

    // conversion sequence: settle delay then one polarity conversion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state         <= chop_seq_pkg::SEQ_IDLE;
            cnt           <= '0;
            polarity_swap <= 1'b0;
            have_prev     <= 1'b0;
            prev_sample   <= '0;
            conv_active   <= 1'b0;
        end else if (restart) begin
            state         <= chop_seq_pkg::SEQ_SETTLE;
            cnt           <= CW'(delay_cfg);
            polarity_swap <= 1'b0;
            have_prev     <= 1'b0;
            conv_active   <= 1'b1;
        end else if (stop_cmd) begin
            state         <= chop_seq_pkg::SEQ_IDLE;
            polarity_swap <= 1'b0;
            have_prev     <= 1'b0;
            conv_active   <= 1'b0;
        end else if (mod_tick) begin
            unique case (state)
                chop_seq_pkg::SEQ_IDLE: begin
                    conv_active <= 1'b0;
                end
                chop_seq_pkg::SEQ_SETTLE: begin
                    if (cnt == '0) begin
                        state <= chop_seq_pkg::SEQ_CONVERT;
                        cnt   <= conv_len(rate_cfg[chop_seq_pkg::FILTER_BIT], rate_idx);
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                chop_seq_pkg::SEQ_CONVERT: begin
                    if (cnt > CW'(1)) begin
                        cnt <= cnt - 1'b1;
                    end else begin
                        prev_sample <= filter_data;
                        have_prev   <= chop_en;
                        // each conversion carries its own settling delay
                        cnt         <= CW'(delay_cfg);
                        if (chop_en) begin
                            polarity_swap <= ~polarity_swap;
                        end
                        // single shot ends after one result
                        if (!cont_mode && (!chop_en || have_prev)) begin
                            state         <= chop_seq_pkg::SEQ_IDLE;
                            conv_active   <= 1'b0;
                            polarity_swap <= 1'b0;
                        end else begin
                            state <= chop_seq_pkg::SEQ_SETTLE;
                        end
                    end
                end
            endcase
        end
    end

    wire conv_done = mod_tick && !restart && !stop_cmd &&
                     state == chop_seq_pkg::SEQ_CONVERT && cnt <= CW'(1);

    // result and its sticky ready flag; new result wins over read clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result       <= '0;
            result_valid <= 1'b0;
            ready_flag   <= 1'b0;
        end else begin
            result_valid <= 1'b0;
            if (apb_rd && paddr == chop_seq_pkg::ADDR_RESULT)
                ready_flag <= 1'b0;
            if (conv_done) begin
                if (!chop_en) begin
                    result       <= filter_data;
                    result_valid <= 1'b1;
                    ready_flag   <= 1'b1;
                end else if (have_prev) begin
                    // normal and reversed samples: half the difference cancels offset
                    result       <= polarity_swap ?
                                    average(prev_sample, DW'(-$signed(filter_data))) :
                                    average(filter_data, DW'(-$signed(prev_sample)));
                    result_valid <= 1'b1;
                    ready_flag   <= 1'b1;
                end
            end
        end
    end
endmodule // global_chop_sequencer

// >>> verification/chop_seq_chk_sva.sv
// assertions on the chop sequencer ports
`timescale 1ns/1ps
module chop_seq_chk (
    input wire logic        pclk,          // clock
    input wire logic        presetn,       // reset, active low
    input wire logic        psel,          // apb select
    input wire logic        penable,       // apb enable
    input wire logic        pready,        // apb ready
    input wire logic        pslverr,       // apb error
    input wire logic        start_pin,     // start pin
    input wire logic        polarity_swap, // inputs reversed
    input wire logic        conv_active,   // busy
    input wire logic [23:0] result,        // result
    input wire logic        result_valid   // result strobe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_pulse_a:
        assert property (pready |=> !pready) else $error("pready too long");
    wait_state_a:
        assert property (psel && !penable |=> !pready ##1 pready) else $error("bad wait");
    err_ready_a:
        assert property (pslverr |-> pready) else $error("pslverr without pready");
    pin_start_a:
        assert property ($rose(start_pin) |-> ##[1:6] conv_active) else $error("no start");
    pair_normal_a:
        assert property ($rose(conv_active) |-> !polarity_swap) else $error("bad polarity");
    idle_normal_a:
        assert property (!conv_active |-> !polarity_swap) else $error("swap while idle");
    valid_pulse_a:
        assert property (result_valid |=> !result_valid) else $error("long strobe");
    result_hold_a:
        assert property (!result_valid |-> $stable(result)) else $error("result moved");
endmodule // chop_seq_chk

bind global_chop_sequencer chop_seq_chk i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .start_pin(start_pin),
    .polarity_swap(polarity_swap), .conv_active(conv_active),
    .result(result), .result_valid(result_valid)
);

// >>> verification/conv_host_model.sv
// host start pin and converter front end with input offset
`timescale 1ns/1ps
module conv_host_model #(
    parameter logic [23:0] LEVEL  = 24'h000064, // true input value
    parameter logic [23:0] OFFSET = 24'h000007  // offset that chop removes
) (
    input  wire logic        pclk,          // clock
    input  wire logic        polarity_swap, // inputs reversed
    output logic             start_pin,     // start pin
    output logic      [23:0] filter_data    // converter sample
);
    initial start_pin = 1'b0;
    // reversal negates the signal but not the offset
    assign filter_data = polarity_swap ? OFFSET - LEVEL : OFFSET + LEVEL;
    task automatic pulse_start();
        @(posedge pclk);
        start_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        start_pin <= 1'b0;
    endtask
endmodule // conv_host_model

// >>> verification/tb_global_chop_sequencer.sv
// self-checking bench for the chop sequencer
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module tb_global_chop_sequencer;
    localparam logic [23:0] LV = 24'h000064;
    localparam logic [23:0] OF = 24'h000007;
    localparam int          NR = 5;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, start_pin, polarity_swap;
    logic        conv_active, result_valid, er, sw;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [23:0] filter_data, result;
    int          cyc = 0, t0, lat, g0, g1, g2, err_count = 0, num_checks = 0;
    logic [7:0]  row_cfg [NR] = '{8'h00, 8'h20, 8'h30, 8'h20, 8'h10};
    logic        row_pin [NR] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [23:0] row_res [NR] = '{LV + OF, LV, LV, LV, LV + OF};
    int          row_lat [NR] = '{28, 56, 156, 56, 78};

    global_chop_sequencer #(.MOD_DIV(1), .COUNT_SHIFT(12)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .start_pin(start_pin),
        .filter_data(filter_data), .polarity_swap(polarity_swap),
        .conv_active(conv_active), .result(result), .result_valid(result_valid)
    );
    conv_host_model #(.LEVEL(LV), .OFFSET(OF)) i_host (
        .pclk(pclk), .polarity_swap(polarity_swap), .start_pin(start_pin),
        .filter_data(filter_data)
    );

    always #5 pclk = ~pclk;

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_res(input int lim);
        int n = 0;
        sw = 1'b0;
        while (result_valid !== 1'b1 && n < lim) begin
            @(posedge pclk);
            sw = sw | polarity_swap;
            n++;
        end
        lat = cyc - t0;
        if (result_valid !== 1'b1) begin
            err_count++;
            $display("[ERR] result_valid exp 1 got 0");
        end
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, chop_seq_pkg::ADDR_RATE_CFG, 32'h0);
        `CHK("rate_cfg reset", 32'h0, rd)
        apb(1'b0, chop_seq_pkg::ADDR_DELAY, 32'h0);
        `CHK("delay reset", 32'h0000000e, rd)
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped err", 1'b1, er)
        `CHK("unmapped data", 32'h0, rd)
        apb(1'b1, chop_seq_pkg::ADDR_DELAY, 32'h2);
        for (int i = 0; i < NR; i++) begin
            apb(1'b1, chop_seq_pkg::ADDR_RATE_CFG, {24'h0, row_cfg[i]});
            apb(1'b0, chop_seq_pkg::ADDR_STATUS, 32'h0);
            `CHK("status chop", row_cfg[i][5], rd[chop_seq_pkg::ST_CHOP_BIT])
            if (row_pin[i]) begin
                t0 = cyc;
                i_host.pulse_start();
            end else begin
                apb(1'b1, chop_seq_pkg::ADDR_CONTROL, 32'h1);
                t0 = cyc;
            end
            wait_res(400);
            `CHK("result", row_res[i], result)
            `CHK("swap seen", row_cfg[i][5], sw)
            `CHK("latency", 1'b1, lat >= row_lat[i] && lat <= row_lat[i] + 10)
            repeat (3) @(posedge pclk);
            `CHK("single idle", 1'b0, conv_active)
        end
        apb(1'b1, chop_seq_pkg::ADDR_RATE_CFG, 32'h60);
        apb(1'b1, chop_seq_pkg::ADDR_CONTROL, 32'h1);
        t0 = cyc;
        wait_res(400);
        g0 = lat;
        @(posedge pclk);
        t0 = cyc;
        wait_res(400);
        g1 = lat;
        `CHK("cont result", LV, result)
        @(posedge pclk);
        t0 = cyc;
        wait_res(400);
        g2 = lat;
        `CHK("cont result", LV, result)
        `CHK("gap steady", g1, g2)
        `CHK("gap length", 1'b1, g1 >= 26 && g1 <= 29)
        `CHK("half time", 1'b1, g0 >= 2 * g1 - 4 && g0 <= 2 * g1 + 10)
        while (polarity_swap !== 1'b1) @(posedge pclk);
        apb(1'b1, chop_seq_pkg::ADDR_CONTROL, 32'h1);
        t0 = cyc;
        repeat (3) @(posedge pclk);
        `CHK("restart normal", 1'b0, polarity_swap)
        wait_res(400);
        `CHK("restart pair", 1'b1, lat >= 54)
        apb(1'b0, chop_seq_pkg::ADDR_STATUS, 32'h0);
        `CHK("ready set", 1'b1, rd[chop_seq_pkg::ST_READY_BIT])
        `CHK("pair polarity", 1'b0, rd[chop_seq_pkg::ST_POL_BIT])
        `CHK("busy", 1'b1, rd[chop_seq_pkg::ST_BUSY_BIT])
        apb(1'b0, chop_seq_pkg::ADDR_RESULT, 32'h0);
        `CHK("result reg", {8'h00, LV}, rd)
        apb(1'b0, chop_seq_pkg::ADDR_STATUS, 32'h0);
        `CHK("ready clear", 1'b0, rd[chop_seq_pkg::ST_READY_BIT])
        // chop enable change in mid-run must restart at normal polarity
        while (polarity_swap !== 1'b1) @(posedge pclk);
        apb(1'b1, chop_seq_pkg::ADDR_RATE_CFG, 32'h40);
        repeat (3) @(posedge pclk);
        `CHK("chop off normal", 1'b0, polarity_swap)
        wait_res(400);
        `CHK("chop off result", LV + OF, result)
        apb(1'b1, chop_seq_pkg::ADDR_CONTROL, 32'h2);
        repeat (3) @(posedge pclk);
        `CHK("stopped", 1'b0, conv_active)
        // reset in mid-run
        apb(1'b1, chop_seq_pkg::ADDR_CONTROL, 32'h1);
        repeat (10) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK("reset busy", 1'b0, conv_active)
        `CHK("reset result", 24'h000000, result)
        presetn <= 1'b1;
        apb(1'b0, chop_seq_pkg::ADDR_RATE_CFG, 32'h0);
        `CHK("rate_cfg again", 32'h0, rd)
        stop_test();
    end
endmodule // tb_global_chop_sequencer
